// ==== rtl/scrg_defs.vh ====
// timing constants and field positions for the system clock and reset generator
// assumes a 50 MHz core clock; included by bare name
`ifndef SCRG_DEFS_VH
`define SCRG_DEFS_VH
`define SCRG_CORE_CLK_MHZ 50
`define SCRG_STABLE_NS 200
`define SCRG_STABLE_CYC ((`SCRG_STABLE_NS * `SCRG_CORE_CLK_MHZ + 999) / 1000)
`define SCRG_STABLE_W 4
`define SCRG_VID_DIV 4
`define SCRG_VID_DIV_W 2
`define SCRG_PH_W 2
`define SCRG_PH_0 2'h0
`define SCRG_PH_90 2'h1
`define SCRG_PH_180 2'h2
`define SCRG_PH_270 2'h3
`define SCRG_FX_MUL 3
`define SCRG_FX_W 2
`endif

// ==== rtl/scrg_clk_mgr.v ====
// one clock manager model: qualifies a lock input and reports skew-free tick phase
// assumes i_ref_tick comes from logic on the core clock; lock from a pin
module scrg_clk_mgr
(
	input wire i_core_clk,
	input wire i_rst_n,
	input wire i_lock_pin,
	input wire i_ref_tick,
	output reg o_locked,
	output reg o_aligned_tick
);
	reg lock_meta;
	reg lock_sync;

	always @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			lock_meta <= 1'h0;
			lock_sync <= 1'h0;
			o_locked <= 1'h0;
			o_aligned_tick <= 1'h0;
		end
		else
		begin
			lock_meta <= i_lock_pin;
			lock_sync <= lock_meta;
			o_locked <= lock_sync;
			// tick re-timed to the reference edge, so skew is removed
			o_aligned_tick <= lock_sync & i_ref_tick;
		end
	end
endmodule

// ==== rtl/scrg_top.v ====
// system clock enables and system reset sequencer
// assumes one 50 MHz core clock; clock manager lock flags arrive as pins
`include "scrg_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - hold reset until main manager locks
// - release after lock stable several cycles
// - main bus clock enables from reference
// - quarter-phase enables at 0/90/180/270 degrees
// - synthesized processor rate enable, core divided by three
// - video enable is main divided by four
// - all enables but the synthesized one derive from one counter
// - memory return clock manager lock and alignment
// - external sram clock manager alignment
// - register bus master/slave integer-ratio synchronous
module scrg_top
(
	input wire i_core_clk,
	input wire i_rst_n,
	input wire i_main_lock,
	input wire i_mem_lock,
	input wire i_sram_lock,
	output reg o_sys_rst_n,
	output reg o_bus_clk_en,
	output reg [3:0] o_phase_shifted_clock_outputs,
	output reg o_synthesized_clock_output,
	output reg o_video_clk_en,
	output reg o_mem_clk_en,
	output reg o_sram_clk_en,
	output reg o_locked
);

	////////////////////////////////////////////////////////////////////////////////
	localparam ST_HOLD = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_RUN = 2'h2;

	reg lock_meta;
	reg lock_sync;
	reg [1:0] state;
	reg [1:0] next_state;
	reg [`SCRG_STABLE_W-1:0] stable_cnt;
	reg [`SCRG_STABLE_W-1:0] next_stable_cnt;
	reg [`SCRG_PH_W-1:0] phase;
	reg [`SCRG_VID_DIV_W-1:0] vid_cnt;
	reg [`SCRG_FX_W-1:0] fx_cnt;
	wire mem_locked;
	wire mem_tick;
	wire sram_locked;
	wire sram_tick;
	wire all_locked;
	wire ref_tick;
	wire [3:0] phase_hit;
	genvar gi;

	////////////////////////////////////////////////////////////////////////////////
	// lock pin is asynchronous, two stages before use
	always @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			lock_meta <= 1'h0;
			lock_sync <= 1'h0;
		end
		else
		begin
			lock_meta <= i_main_lock;
			lock_sync <= lock_meta;
		end
	end

	scrg_clk_mgr u_mem_mgr
	(
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_lock_pin(i_mem_lock),
		.i_ref_tick(ref_tick),
		.o_locked(mem_locked),
		.o_aligned_tick(mem_tick)
	);

	scrg_clk_mgr u_sram_mgr
	(
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_lock_pin(i_sram_lock),
		.i_ref_tick(ref_tick),
		.o_locked(sram_locked),
		.o_aligned_tick(sram_tick)
	);

	assign all_locked = lock_sync;
	// raised at phase 270: manager stage plus output stage land it beside the bus enable
	assign ref_tick = (state == ST_RUN) && (phase == `SCRG_PH_270);

	////////////////////////////////////////////////////////////////////////////////
	// reset sequencer
	always @*
	begin
		next_state = state;
		next_stable_cnt = stable_cnt;
		case (state)
			ST_HOLD:
			begin
				next_stable_cnt = {`SCRG_STABLE_W{1'h0}};
				if (all_locked)
				begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT:
			begin
				if (!all_locked)
				begin
					next_state = ST_HOLD;
				end
				else if (stable_cnt == `SCRG_STABLE_CYC - 1)
				begin
					next_state = ST_RUN;
				end
				else
				begin
					next_stable_cnt = stable_cnt + 1'h1;
				end
			end
			ST_RUN:
			begin
				if (!all_locked)
				begin
					next_state = ST_HOLD;
				end
			end
			default:
			begin
				next_state = ST_HOLD;
			end
		endcase
	end

	always @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state <= ST_HOLD;
			stable_cnt <= {`SCRG_STABLE_W{1'h0}};
		end
		else
		begin
			state <= next_state;
			stable_cnt <= next_stable_cnt;
		end
	end

	// release only as phase 270 turns to phase 0, so receivers see a main clock edge
	always @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_sys_rst_n <= 1'h0;
		end
		else
		begin
			o_sys_rst_n <= (next_state == ST_RUN) && (o_sys_rst_n || (phase == `SCRG_PH_270));
		end
	end

	always @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_locked <= 1'h0;
		end
		else
		begin
			o_locked <= all_locked;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// one phase counter drives every enable but the synthesized one, which runs from its own fx_cnt
	always @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			phase <= `SCRG_PH_0;
		end
		else
		begin
			phase <= phase + 1'h1;
		end
	end

	// bus, peripheral and register bus share this one enable, integer related
	always @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_bus_clk_en <= 1'h0;
		end
		else
		begin
			o_bus_clk_en <= all_locked && (phase == `SCRG_PH_0);
		end
	end

	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_phase
			assign phase_hit[gi] = (phase == gi);
		end
	endgenerate

	always @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_phase_shifted_clock_outputs <= 4'h0;
		end
		else
		begin
			o_phase_shifted_clock_outputs <= all_locked ? phase_hit : 4'h0;
		end
	end

	always @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			fx_cnt <= {`SCRG_FX_W{1'h0}};
		end
		else if (fx_cnt == `SCRG_FX_MUL - 1)
		begin
			fx_cnt <= {`SCRG_FX_W{1'h0}};
		end
		else
		begin
			fx_cnt <= fx_cnt + 1'h1;
		end
	end

	always @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_synthesized_clock_output <= 1'h0;
		end
		else
		begin
			o_synthesized_clock_output <= all_locked && (fx_cnt == {`SCRG_FX_W{1'h0}});
		end
	end

	always @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			vid_cnt <= {`SCRG_VID_DIV_W{1'h0}};
		end
		else if (all_locked && (phase == `SCRG_PH_0))
		begin
			vid_cnt <= vid_cnt + 1'h1;
		end
	end

	always @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_video_clk_en <= 1'h0;
		end
		else
		begin
			o_video_clk_en <= all_locked && (phase == `SCRG_PH_0) && (vid_cnt == {`SCRG_VID_DIV_W{1'h0}});
		end
	end

	// main lock gates these too, so they never outlive the bus enable
	always @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_mem_clk_en <= 1'h0;
		end
		else
		begin
			o_mem_clk_en <= all_locked && mem_locked && mem_tick;
		end
	end

	always @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_sram_clk_en <= 1'h0;
		end
		else
		begin
			o_sram_clk_en <= all_locked && sram_locked && sram_tick;
		end
	end
endmodule

// ==== tb/scrg_top_sva.sv ====
// checker for the clock and reset generator ports
// assumes bind into scrg_top; one core clock domain
module scrg_top_sva
(
	input wire i_core_clk,
	input wire i_rst_n,
	input wire o_sys_rst_n,
	input wire o_bus_clk_en,
	input wire [3:0] o_phase_shifted_clock_outputs,
	input wire o_synthesized_clock_output,
	input wire o_video_clk_en,
	input wire o_mem_clk_en,
	input wire o_sram_clk_en,
	input wire o_locked
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);
	wire [3:0] ph = o_phase_shifted_clock_outputs;
	logic [3:0] lock_run;
	// unbroken lock cycles, so a glitch inside the wait is caught
	always @(posedge i_core_clk or negedge i_rst_n)
		if (!i_rst_n)
			lock_run <= 4'h0;
		else if (!o_locked)
			lock_run <= 4'h0;
		else if (lock_run != 4'hF)
			lock_run <= lock_run + 4'h1;
	hold_for_lock_a: assert property ($rose(o_sys_rst_n) |-> o_locked) else $error("early release");
	stable_lock_a: assert property ($rose(o_sys_rst_n) |-> lock_run >= 4'hA) else $error("short wait");
	bus_period_a: assert property (o_bus_clk_en |=> !o_bus_clk_en [*3]) else $error("bus rate");
	phase_rotate_a: assert property (o_locked && $past(o_locked) && $past(ph) != 4'h0
		|-> ph == {$past(ph[2:0]), $past(ph[3])}) else $error("phase order");
	fx_period_a: assert property (o_synthesized_clock_output |=> !o_synthesized_clock_output [*2])
		else $error("fx rate");
	video_align_a: assert property (o_video_clk_en |-> o_bus_clk_en) else $error("video align");
	mem_align_a: assert property (o_mem_clk_en |-> o_bus_clk_en) else $error("mem align");
	sram_align_a: assert property (o_sram_clk_en |-> o_bus_clk_en) else $error("sram align");
	loss_reassert_a: assert property ($fell(o_locked) |=> !o_sys_rst_n) else $error("late reassert");
endmodule
bind scrg_top scrg_top_sva u_scrg_top_sva (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
	.o_sys_rst_n(o_sys_rst_n), .o_bus_clk_en(o_bus_clk_en), .o_locked(o_locked),
	.o_phase_shifted_clock_outputs(o_phase_shifted_clock_outputs), .o_video_clk_en(o_video_clk_en),
	.o_synthesized_clock_output(o_synthesized_clock_output), .o_mem_clk_en(o_mem_clk_en),
	.o_sram_clk_en(o_sram_clk_en));

// ==== tb/scrg_sys_model.sv ====
// system logic stand-in: registers the global reset, counts bus enables
// assumes it shares the generator's core clock
module scrg_sys_model
(
	input wire i_core_clk,
	input wire i_sys_rst_n,
	input wire i_bus_clk_en,
	output reg [7:0] o_tick_cnt
);
	timeunit 1ns;
	timeprecision 100ps;
	reg rst_q;
	// local copy hides fanout skew of the global reset
	always @(posedge i_core_clk)
		rst_q <= i_sys_rst_n;
	always @(posedge i_core_clk)
		if (!rst_q)
			o_tick_cnt <= 8'h00;
		else if (i_bus_clk_en)
			o_tick_cnt <= o_tick_cnt + 8'h01;
endmodule

// ==== tb/scrg_top_bench.sv ====
// self-checking bench for the clock and reset generator
// assumes scrg_top, its checker and the system model
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t mismatch", $time); end end
module scrg_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_core_clk = 0, i_rst_n = 0, i_main_lock = 0, i_mem_lock = 0, i_sram_lock = 0;
	wire o_sys_rst_n, o_bus_clk_en, o_synthesized_clock_output, o_video_clk_en, o_mem_clk_en, o_sram_clk_en, o_locked;
	wire [3:0] ph;
	wire [7:0] rx;
	logic [7:0] r0;
	int error_cnt = 0, checks = 0, cyc = 0, seen, n[6];
	scrg_top u_scrg_top (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_main_lock(i_main_lock),
		.i_mem_lock(i_mem_lock), .i_sram_lock(i_sram_lock), .o_sys_rst_n(o_sys_rst_n), .o_bus_clk_en(o_bus_clk_en),
		.o_phase_shifted_clock_outputs(ph), .o_synthesized_clock_output(o_synthesized_clock_output),
		.o_video_clk_en(o_video_clk_en), .o_mem_clk_en(o_mem_clk_en), .o_sram_clk_en(o_sram_clk_en), .o_locked(o_locked));
	scrg_sys_model u_scrg_sys_model (.i_core_clk(i_core_clk), .i_sys_rst_n(o_sys_rst_n),
		.i_bus_clk_en(o_bus_clk_en), .o_tick_cnt(rx));
	////////////////////////////////////////////////////////////////////////////////
	task step(input int k);
		repeat (k) @(posedge i_core_clk);
		#2;
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// lock lost in mid-count must restart the stable wait
	task t_glitch;
		i_main_lock = 1;
		step(8);
		i_main_lock = 0;
		step(2);
		i_main_lock = 1;
		step(12);
		`CHK(o_sys_rst_n, 1'b0)
		seen = 0;
		repeat (8)
		begin
			step(1);
			if (o_sys_rst_n === 1'b1)
				seen = 1;
		end
		`CHK(seen, 1)
	endtask
	// any 48-cycle window holds whole periods of every enable
	task t_run;
		n = '{default: 0};
		r0 = rx;
		repeat (48)
		begin
			step(1);
			n[0] += (o_bus_clk_en === 1'b1);
			n[1] += (ph === 4'h2);
			n[2] += (o_synthesized_clock_output === 1'b1);
			n[3] += (o_video_clk_en === 1'b1);
			n[4] += (o_mem_clk_en === 1'b1);
			n[5] += (o_sram_clk_en === 1'b1);
		end
		`CHK(n[0], 12)
		`CHK(n[1], 12)
		`CHK(n[2], 16)
		`CHK(n[3], 3)
		`CHK(n[4], 12)
		`CHK(n[5], 12)
		`CHK(8'(rx - r0), 8'h0C)
	endtask
	task t_loss;
		i_main_lock = 0;
		step(5);
		`CHK(o_sys_rst_n, 1'b0)
		`CHK(o_locked, 1'b0)
		i_main_lock = 1;
		step(18);
		`CHK(o_sys_rst_n, 1'b1)
		`CHK(o_locked, 1'b1)
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		forever #10 i_core_clk = ~i_core_clk;
	end
	always @(posedge i_core_clk)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			error_cnt++;
			report_and_stop;
		end
	end
	initial
	begin
		i_mem_lock = 1;
		i_sram_lock = 1;
		step(20);
		i_rst_n = 1;
		step(2);
		t_glitch;
		t_run;
		t_loss;
		t_run;
		report_and_stop;
	end
endmodule
